// file: src/flash_mode_pkg.sv
`default_nettype none
package flash_mode_pkg;
    // Operating modes decoded at reset release
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_PROG = 2'b01,
        MODE_ILLEGAL = 2'b10
    } op_mode_e;
    // Programming links chosen by pulse count
    typedef enum logic [1:0] {
        LINK_NONE = 2'b00,
        LINK_ASYNC = 2'b01,
        LINK_CLOCKED = 2'b10,
        LINK_CLOCKED_HS = 2'b11
    } link_e;
    // Flash macro operations
    typedef enum logic [3:0] {
        OP_INIT = 4'h0,
        OP_ERASE = 4'h1,
        OP_WRITE = 4'h2,
        OP_VERIFY = 4'h3,
        OP_BLANK = 4'h4,
        OP_PIN_CHECK = 4'h5,
        OP_GET_INFO = 4'h6,
        OP_SET_INFO = 4'h7,
        OP_SWAP = 4'h8,
        OP_READ = 4'h9
    } flash_op_e;
    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BUSY = 2'b01,
        ST_DONE = 2'b10
    } seq_state_e;
    localparam int PULSE_MAX = 11;
    localparam logic [3:0] PULSE_ASYNC = 4'h0;
    localparam logic [3:0] PULSE_CLOCKED = 4'h8;
    localparam logic [3:0] PULSE_CLOCKED_HS = 4'h9;
    localparam int SEL_IDLE_CYCLES = 64;
    localparam int OP_CYCLES = 16;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 32;
    localparam int BLOCK_W = 4;
    localparam logic [1:0] SWAP_MASK = 2'h2;
    localparam logic [ADDR_W-1:0] RESET_VECTOR = 20'h00000;
endpackage : flash_mode_pkg
`default_nettype wire

// file: src/flash_mode_and_self_program_ctrl.sv
// Operation
// - Protect low gives normal; protect high, aux low gives programming; both high illegal.
// - Three programming links: async serial (selectable, but rx is ignored and tx held high), clocked serial, clocked plus handshake.
// - Unused pins hold their reset state while programming.
// - Boot swap exchanges blocks 0,1 with blocks 2,3.
// - No flash instruction fetch while a rewrite runs.
// - Rewrite allowed only while protect pin is high.
// - Maskable interrupts vector to RAM-registered handler during self programming.
// - Macro offers init, erase, write, verify, blank, pin check, info, swap, read.
// - Up to 11 protect-pin pulses select the programming link.
// - Clocked links: programmer clocks, device is slave, MSB first.
`timescale 1ns/1ps
`default_nettype none
module flash_mode_and_self_program_ctrl (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic mode_protect_pin_in,
    input wire logic mode_aux_pin_in,
    input wire logic async_rx_pin_in,
    input wire logic clocked_data_in_in,
    input wire logic clocked_serial_clock_in,
    output logic async_tx_pin_out,
    output logic clocked_data_out_out,
    output logic handshake_port_pin_out,
    output logic handshake_port_pin_oe_out,
    output logic port_hold_reset_out,
    output logic [1:0] op_mode_out,
    output logic [1:0] link_out,
    output logic link_valid_out,
    output logic [7:0] rx_byte_out,
    output logic rx_byte_valid_out,
    input wire logic [7:0] tx_byte_in,
    input wire logic op_start_in,
    input wire logic [3:0] op_code_in,
    input wire logic [flash_mode_pkg::BLOCK_W-1:0] op_block_in,
    input wire logic [flash_mode_pkg::ADDR_W-1:0] op_addr_in,
    output logic op_busy_out,
    output logic op_done_out,
    output logic op_error_out,
    output logic [flash_mode_pkg::DATA_W-1:0] op_result_out,
    output logic fetch_block_out,
    input wire logic [flash_mode_pkg::ADDR_W-1:0] fetch_addr_in,
    output logic [flash_mode_pkg::ADDR_W-1:0] phys_addr_out,
    input wire logic handler_wr_in,
    input wire logic [flash_mode_pkg::ADDR_W-1:0] handler_addr_in,
    input wire logic irq_in,
    output logic [flash_mode_pkg::ADDR_W-1:0] irq_vector_out
);
    logic sampled;
    logic [1:0] op_mode;
    logic prot_q;
    logic [3:0] pulse_cnt;
    logic [6:0] idle_cnt;
    logic link_done;
    logic [1:0] link;
    logic sck_q;
    logic [2:0] bit_cnt;
    logic [7:0] rx_sh;
    logic [7:0] tx_sh;
    logic swapped;
    logic [flash_mode_pkg::ADDR_W-1:0] handler;
    flash_mode_pkg::seq_state_e state;
    logic [4:0] op_cnt;
    logic [3:0] cur_op;
    logic [1:0] phys_top;

    // Maps a logical block pair through the swap
    function automatic logic [1:0] swap_map(input logic [1:0] top, input logic sw);
        swap_map = sw ? (top ^ flash_mode_pkg::SWAP_MASK) : top;
    endfunction : swap_map

    ////////////////////////////////////////////////////////////////////
    // sample once
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            sampled <= 1'b0;
            op_mode <= flash_mode_pkg::MODE_NORMAL;
        end
        else if (!sampled)
        begin
            sampled <= 1'b1;
            if (!mode_protect_pin_in)
                op_mode <= flash_mode_pkg::MODE_NORMAL;
            else if (!mode_aux_pin_in)
                op_mode <= flash_mode_pkg::MODE_PROG;
            else
                op_mode <= flash_mode_pkg::MODE_ILLEGAL;
        end
    end
    assign op_mode_out = op_mode;

    assign port_hold_reset_out = (op_mode == flash_mode_pkg::MODE_PROG);

    ////////////////////////////////////////////////////////////////////
    // count selection pulses
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            prot_q <= 1'b1;
            pulse_cnt <= 4'h0;
            idle_cnt <= 7'h00;
            link_done <= 1'b0;
            link <= flash_mode_pkg::LINK_NONE;
        end
        else if (sampled && op_mode == flash_mode_pkg::MODE_PROG && !link_done)
        begin
            prot_q <= mode_protect_pin_in;
            if (prot_q && !mode_protect_pin_in)
            begin
                idle_cnt <= 7'h00;
                if (pulse_cnt < 4'(flash_mode_pkg::PULSE_MAX))
                    pulse_cnt <= pulse_cnt + 4'h1;
            end
            else if (idle_cnt == 7'(flash_mode_pkg::SEL_IDLE_CYCLES))
            begin
                link_done <= 1'b1;
                if (pulse_cnt == flash_mode_pkg::PULSE_ASYNC)
                    link <= flash_mode_pkg::LINK_ASYNC;
                else if (pulse_cnt == flash_mode_pkg::PULSE_CLOCKED)
                    link <= flash_mode_pkg::LINK_CLOCKED;
                else if (pulse_cnt == flash_mode_pkg::PULSE_CLOCKED_HS)
                    link <= flash_mode_pkg::LINK_CLOCKED_HS;
                else
                    link <= flash_mode_pkg::LINK_NONE;
            end
            else
                idle_cnt <= idle_cnt + 7'h01;
        end
    end
    assign link_out = link;
    assign link_valid_out = link_done;

    ////////////////////////////////////////////////////////////////////
    // slave shifter, MSB first
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            sck_q <= 1'b1;
            bit_cnt <= 3'h0;
            rx_sh <= 8'h00;
            tx_sh <= 8'h00;
            rx_byte_out <= 8'h00;
            rx_byte_valid_out <= 1'b0;
            clocked_data_out_out <= 1'b1;
        end
        else
        begin
            sck_q <= clocked_serial_clock_in;
            rx_byte_valid_out <= 1'b0;
            if (link[1] && link_done)
            begin
                if (sck_q && !clocked_serial_clock_in)
                begin
                    if (bit_cnt == 3'h0)
                    begin
                        clocked_data_out_out <= tx_byte_in[7];
                        tx_sh <= {tx_byte_in[6:0], 1'b0};
                    end
                    else
                    begin
                        clocked_data_out_out <= tx_sh[7];
                        tx_sh <= {tx_sh[6:0], 1'b0};
                    end
                end
                else if (!sck_q && clocked_serial_clock_in)
                begin
                    rx_sh <= {rx_sh[6:0], clocked_data_in_in};
                    bit_cnt <= bit_cnt + 3'h1;
                    if (bit_cnt == 3'h7)
                    begin
                        rx_byte_out <= {rx_sh[6:0], clocked_data_in_in};
                        rx_byte_valid_out <= 1'b1;
                    end
                end
            end
        end
    end
    assign async_tx_pin_out = 1'b1;
    assign handshake_port_pin_out = (state == flash_mode_pkg::ST_IDLE);
    assign handshake_port_pin_oe_out = link_done && (link == flash_mode_pkg::LINK_CLOCKED_HS);

    ////////////////////////////////////////////////////////////////////
    // macro sequencer
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            state <= flash_mode_pkg::ST_IDLE;
            op_cnt <= 5'h00;
            cur_op <= flash_mode_pkg::OP_INIT;
            op_done_out <= 1'b0;
            op_error_out <= 1'b0;
            op_result_out <= '0;
            swapped <= 1'b0;
        end
        else
        begin
            unique case (state)
                flash_mode_pkg::ST_IDLE:
                begin
                    op_done_out <= 1'b0;
                    if (op_start_in)
                    begin
                        cur_op <= op_code_in;
                        op_cnt <= 5'h00;
                        op_error_out <= !mode_protect_pin_in
                            && op_code_in != flash_mode_pkg::OP_INIT
                            && op_code_in != flash_mode_pkg::OP_PIN_CHECK
                            && op_code_in != flash_mode_pkg::OP_GET_INFO
                            && op_code_in != flash_mode_pkg::OP_READ;
                        state <= flash_mode_pkg::ST_BUSY;
                    end
                end
                flash_mode_pkg::ST_BUSY:
                begin
                    op_cnt <= op_cnt + 5'h01;
                    if (op_cnt == 5'(flash_mode_pkg::OP_CYCLES - 1))
                        state <= flash_mode_pkg::ST_DONE;
                end
                flash_mode_pkg::ST_DONE:
                begin
                    op_done_out <= 1'b1;
                    state <= flash_mode_pkg::ST_IDLE;
                    if (cur_op == flash_mode_pkg::OP_PIN_CHECK)
                        op_result_out <= {{(flash_mode_pkg::DATA_W-1){1'b0}}, mode_protect_pin_in};
                    else
                        op_result_out <= {{(flash_mode_pkg::DATA_W-flash_mode_pkg::BLOCK_W){1'b0}},
                            op_block_in};
                    if (cur_op == flash_mode_pkg::OP_SWAP && !op_error_out)
                        swapped <= !swapped;
                end
                default:
                    state <= flash_mode_pkg::ST_IDLE;
            endcase
        end
    end
    assign op_busy_out = (state != flash_mode_pkg::ST_IDLE);

    assign fetch_block_out = op_busy_out;

    assign phys_top = swap_map(fetch_addr_in[flash_mode_pkg::ADDR_W-1 -: 2], swapped);
    assign phys_addr_out = {phys_top, fetch_addr_in[flash_mode_pkg::ADDR_W-3:0]};

    ////////////////////////////////////////////////////////////////////
    // RAM handler vector
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
            handler <= flash_mode_pkg::RESET_VECTOR;
        else if (handler_wr_in)
            handler <= handler_addr_in;
    end
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
            irq_vector_out <= flash_mode_pkg::RESET_VECTOR;
        else if (irq_in)
            irq_vector_out <= op_busy_out ? handler : flash_mode_pkg::RESET_VECTOR;
    end
endmodule : flash_mode_and_self_program_ctrl
`default_nettype wire

// file: sim/flash_mode_and_self_program_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
module flash_ctrl_checker (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic mode_protect_pin_in,
    input wire logic mode_aux_pin_in,
    input wire logic op_start_in,
    input wire logic [3:0] op_code_in,
    input wire logic op_busy_out,
    input wire logic op_done_out,
    input wire logic op_error_out,
    input wire logic fetch_block_out,
    input wire logic port_hold_reset_out,
    input wire logic [1:0] op_mode_out,
    input wire logic [1:0] link_out,
    input wire logic link_valid_out,
    input wire logic handshake_port_pin_oe_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);
    chk_mode_decode: assert property (rst_n_in && !$past(rst_n_in) |=> op_mode_out ==
        (!$past(mode_protect_pin_in) ? 2'b00 : ($past(mode_aux_pin_in) ? 2'b10 : 2'b01)))
        else $error("mode decode wrong");
    chk_mode_hold: assert property (rst_n_in && $past(rst_n_in) && $past(rst_n_in, 2)
        |-> $stable(op_mode_out)) else $error("mode changed");
    chk_port_hold: assert property (port_hold_reset_out == (op_mode_out == 2'b01))
        else $error("port hold wrong");
    chk_hs_enable: assert property (handshake_port_pin_oe_out |-> link_out == 2'b11)
        else $error("handshake enable wrong");
    chk_link_stays: assert property (link_valid_out |=> link_valid_out && $stable(link_out))
        else $error("link choice moved");
    chk_fetch_block: assert property (fetch_block_out == op_busy_out)
        else $error("fetch block wrong");
    chk_fetch_start: assert property (op_start_in && !op_busy_out
        |=> fetch_block_out [*8]) else $error("fetch not blocked");
    chk_op_length: assert property ($rose(op_busy_out) |-> ##17 op_done_out)
        else $error("operation length wrong");
    chk_done_pulse: assert property (op_done_out |=> !op_done_out)
        else $error("done not a pulse");
    chk_write_guard: assert property (op_start_in && !op_busy_out &&
        (op_code_in inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8})
        |=> op_error_out == !$past(mode_protect_pin_in)) else $error("write guard wrong");
    cover property ($rose(link_valid_out));
    cover property (op_done_out && op_error_out);
    cover property (op_mode_out == 2'b10);
endmodule : flash_ctrl_checker
bind flash_mode_and_self_program_ctrl flash_ctrl_checker u_chk (.clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in), .mode_protect_pin_in(mode_protect_pin_in),
    .mode_aux_pin_in(mode_aux_pin_in), .op_start_in(op_start_in), .op_code_in(op_code_in),
    .op_busy_out(op_busy_out), .op_done_out(op_done_out), .op_error_out(op_error_out),
    .fetch_block_out(fetch_block_out), .port_hold_reset_out(port_hold_reset_out),
    .op_mode_out(op_mode_out), .link_out(link_out), .link_valid_out(link_valid_out),
    .handshake_port_pin_oe_out(handshake_port_pin_oe_out));
`default_nettype wire

// file: sim/flash_programmer_model.sv
`timescale 1ns/1ps
`default_nettype none
module flash_programmer_model (
    input wire logic clk_in,
    input wire logic dev_so_in,
    output logic rst_n_out = 1'b0,
    output logic protect_out = 1'b0,
    output logic aux_out = 1'b0,
    output logic sclk_out = 1'b1,
    output logic sdo_out = 1'b0
);
    logic [7:0] got = 8'h00;
    task automatic reset_dev(input logic p, input logic a);
        rst_n_out <= 1'b0;
        protect_out <= p;
        aux_out <= a;
        repeat (6) @(posedge clk_in);
        rst_n_out <= 1'b1;
        @(posedge clk_in);
    endtask : reset_dev
    task automatic set_protect(input logic v);
        protect_out <= v;
        @(posedge clk_in);
    endtask : set_protect
    task automatic pulses(input int n);
        repeat (n)
        begin
            protect_out <= 1'b0;
            repeat (2) @(posedge clk_in);
            protect_out <= 1'b1;
            repeat (2) @(posedge clk_in);
        end
    endtask : pulses
    task automatic xfer(input logic [7:0] b);
        for (int i = 7; i >= 0; i--)
        begin
            sclk_out <= 1'b0;
            sdo_out <= b[i];
            repeat (3) @(posedge clk_in);
            sclk_out <= 1'b1;
            got[i] <= dev_so_in;
            repeat (3) @(posedge clk_in);
        end
        sdo_out <= ~b[0];
    endtask : xfer
endmodule : flash_programmer_model
`default_nettype wire

// file: sim/flash_mode_and_self_program_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module flash_mode_and_self_program_ctrl_tb;
    typedef logic [flash_mode_pkg::ADDR_W-1:0] addr_t;
    logic clk = 1'b0;
    logic rst_n, prot, aux, sclk, sdi, so, txp, hs, hs_oe, hold, lvalid, rxv, busy, done, err, fblk;
    logic start = 1'b0;
    logic hwr = 1'b0;
    logic irq = 1'b1;
    logic [1:0] mode, link;
    logic [7:0] rx;
    logic [7:0] txb = 8'h00;
    logic [3:0] code = 4'h0;
    addr_t faddr = 20'h00010;
    addr_t haddr = 20'h01234;
    addr_t paddr, vec;
    logic [31:0] result;
    int bad_count = 0;
    int checked = 0;
    int rx_n = 0;
    always #50 clk = ~clk;
    always @(posedge clk) if (rxv === 1'b1) rx_n <= rx_n + 1;
    flash_programmer_model prog (.clk_in(clk), .dev_so_in(so), .rst_n_out(rst_n),
        .protect_out(prot), .aux_out(aux), .sclk_out(sclk), .sdo_out(sdi));
    flash_mode_and_self_program_ctrl uut (.clk_sys_in(clk), .rst_n_in(rst_n),
        .mode_protect_pin_in(prot), .mode_aux_pin_in(aux), .async_rx_pin_in(1'b1),
        .clocked_data_in_in(sdi), .clocked_serial_clock_in(sclk), .async_tx_pin_out(txp),
        .clocked_data_out_out(so), .handshake_port_pin_out(hs),
        .handshake_port_pin_oe_out(hs_oe), .port_hold_reset_out(hold), .op_mode_out(mode),
        .link_out(link), .link_valid_out(lvalid), .rx_byte_out(rx), .rx_byte_valid_out(rxv),
        .tx_byte_in(txb), .op_start_in(start), .op_code_in(code), .op_block_in(4'h3),
        .op_addr_in(20'h00000), .op_busy_out(busy), .op_done_out(done),
        .op_error_out(err), .op_result_out(result), .fetch_block_out(fblk),
        .fetch_addr_in(faddr), .phys_addr_out(paddr), .handler_wr_in(hwr),
        .handler_addr_in(haddr), .irq_in(irq), .irq_vector_out(vec));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop;
        if (bad_count == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : report_and_stop
    task automatic wait_hi(input int which);
        int n;
        n = 0;
        while ((which == 0 ? done : lvalid) !== 1'b1 && n < 300)
        begin
            @(posedge clk);
            n++;
        end
        if (n == 300)
        begin
            bad_count++;
            $display("MISMATCH %0t timeout", $time);
            report_and_stop();
        end
    endtask : wait_hi
    ////////////////////////////////////////////////////////////////////////////////
    task automatic mode_case(input logic p, input logic a, input logic [1:0] exp);
        prog.reset_dev(p, a);
        prog.set_protect(~p);
        repeat (3) @(posedge clk);
        check(mode, exp);
        check(hold, exp == 2'b01);
    endtask : mode_case
    task automatic link_case(input int n, input logic [1:0] exp);
        prog.reset_dev(1'b1, 1'b0);
        prog.pulses(n);
        repeat (60) @(posedge clk);
        check(lvalid, 1'b0);
        wait_hi(1);
        check(link, exp);
        check(hs_oe, exp == 2'b11);
    endtask : link_case
    task automatic t_serial;
        txb <= 8'h3c;
        prog.xfer(8'ha5);
        repeat (3) @(posedge clk);
        check(rx, 8'ha5);
        check(rx_n, 1);
        check(prog.got, 8'h3c);
        check(hs, 1'b1);
        check(txp, 1'b1);
    endtask : t_serial
    task automatic run_op(input logic [3:0] c, input logic [31:0] res);
        code <= c;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (3) @(posedge clk);
        check(fblk, 1'b1);
        check(vec, 20'h01234);
        check(busy, 1'b1);
        check(hs, 1'b0);
        wait_hi(0);
        check(result, res);
    endtask : run_op
    task automatic t_ops;
        prog.reset_dev(1'b0, 1'b0);
        prog.set_protect(1'b1);
        hwr <= 1'b1;
        @(posedge clk);
        hwr <= 1'b0;
        check(paddr, 20'h00010);
        for (int c = 0; c < 10; c++)
        begin
            run_op(c[3:0], c == 5 ? 32'h1 : 32'h3);
            check(err, 1'b0);
        end
        check(paddr, 20'h80010);
        prog.set_protect(1'b0);
        run_op(4'h1, 32'h3);
        check(err, 1'b1);
        irq <= 1'b0;
        repeat (2) @(posedge clk);
        check(vec, 20'h00000);
        check(busy, 1'b0);
    endtask : t_ops
    initial
    begin
        @(posedge clk);
        mode_case(1'b0, 1'b1, 2'b00);
        mode_case(1'b1, 1'b0, 2'b01);
        mode_case(1'b1, 1'b1, 2'b10);
        link_case(0, 2'b01);
        link_case(8, 2'b10);
        link_case(11, 2'b00);
        link_case(9, 2'b11);
        t_serial();
        t_ops();
        report_and_stop();
    end
endmodule : flash_mode_and_self_program_ctrl_tb
`default_nettype wire
